// ==== shared/spi_port_pkg.sv ====
// register map, control fields, carriers and state record of the spi port
package spi_port_pkg;
	localparam logic [31:0] ADDR_STATUS = 32'hffff_0a00;
	localparam logic [31:0] ADDR_RX     = 32'hffff_0a04;
	localparam logic [31:0] ADDR_TX     = 32'hffff_0a08;
	localparam logic [31:0] ADDR_DIV    = 32'hffff_0a0c;
	localparam logic [31:0] ADDR_CTRL   = 32'hffff_0a10;
	// one-hot decode positions
	localparam int R_STATUS = 0;
	localparam int R_RX     = 1;
	localparam int R_TX     = 2;
	localparam int R_DIV    = 3;
	localparam int R_CTRL   = 4;
	// control field positions
	localparam int C_EN      = 0;
	localparam int C_MASTER  = 1;
	localparam int C_CPHA    = 2;
	localparam int C_CPOL    = 3;
	localparam int C_TMDE    = 6;
	localparam int C_MISO_OE = 9;
	localparam int C_LOOP    = 10;
	localparam int C_RFLUSH  = 12;
	localparam int C_TFLUSH  = 13;
	localparam int C_MODE    = 14;
	// sticky flag vector positions
	localparam int F_ANY = 0;
	localparam int F_UNF = 1;
	localparam int F_TXI = 2;
	localparam int F_RXI = 3;
	localparam int F_OVF = 4;
	// reset values and counts
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam logic [7:0]  DIV_RST        = 8'h00;
	localparam logic [2:0]  FIFO_DEPTH     = 3'h4;
	localparam logic [3:0]  LAST_BIT       = 4'h7;
	localparam logic [4:0]  LAST_EDGE      = 5'h0f;
	localparam logic [4:0]  STALL_HALVES   = 5'h01;

	typedef enum logic [2:0] {
		P_IDLE  = 3'b001,
		P_XFER  = 3'b010,
		P_STALL = 3'b100
	} phase_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic serial_clock_line;
		logic mosi;
		logic miso;
		logic cs_n;
	} pin_in_s;

	typedef struct packed {
		logic serial_clock_line_o;
		logic serial_clock_line_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic cs_n_o;
		logic cs_n_oe;
	} pin_out_s;

	typedef struct packed {
		phase_e          fsm;
		logic [15:0]     ctrl;
		logic [7:0]      div;
		logic [3:0][7:0] txq;
		logic [2:0]      tx_cnt;
		logic [3:0][7:0] rxq;
		logic [2:0]      rx_cnt;
		logic [4:0]      flg;
		logic [7:0]      divcnt;
		logic [4:0]      edge_cnt;
		logic            sclk;
		logic            cs_n;
		logic [7:0]      tx_sh;
		logic [7:0]      rx_sh;
		logic [3:0]      bits;
		logic            first;
		logic [1:0]      txd_cnt;
		logic [31:0]     prdata;
		logic [1:0]      sclk_s;
		logic [1:0]      mosi_s;
		logic [1:0]      miso_s;
		logic [1:0]      cs_s;
		logic            sclk_prev;
	} state_s;
endpackage: spi_port_pkg

// ==== rtl/spi_port_with_status.sv ====
// full-duplex byte spi port, master or slave, with clear-on-read status over apb
//
// Register access over APB was decided locally.
module spi_port_with_status import spi_port_pkg::*; (
	// clock and reset
	input  wire logic     clk,
	input  wire logic     srst,
	// apb slave
	input  wire apb_req_s apb_req,
	output apb_rsp_s      apb_rsp,
	// serial pins
	input  wire pin_in_s  pin_in,
	output pin_out_s      pin_out
);
	state_s     st;
	state_s     next_st;
	logic [4:0] sel;
	logic       setup, rd, wr, en, master, slave, cpha, cpol, tmde, rfl, tfl;
	logic [1:0] mode;
	logic       edge_ev, lead, smp, lnch, din, load, done, start;
	logic [7:0] byte_in;
	logic [4:0] ev, clr;

	function automatic logic [4:0] reg_sel(input logic [31:0] a);
		reg_sel = {a == ADDR_CTRL, a == ADDR_DIV, a == ADDR_TX, a == ADDR_RX, a == ADDR_STATUS};
	endfunction: reg_sel

	function automatic logic [31:0] status_word(input state_s s, input logic [1:0] m);
		logic rex;
		rex = s.rx_cnt > ({1'b0, m} + 3'h1);
		status_word = {20'h0_0000, rex, s.rx_cnt, s.flg[F_OVF], s.flg[F_RXI],
			s.flg[F_TXI], s.flg[F_UNF], s.tx_cnt, s.flg[F_ANY]};
	endfunction: status_word

	always_comb begin
		next_st = st;
		// pins pass two stages before use
		next_st.sclk_s    = {st.sclk_s[0], pin_in.serial_clock_line};
		next_st.mosi_s    = {st.mosi_s[0], pin_in.mosi};
		next_st.miso_s    = {st.miso_s[0], pin_in.miso};
		next_st.cs_s      = {st.cs_s[0], pin_in.cs_n};
		next_st.sclk_prev = st.sclk_s[1];
		en     = st.ctrl[C_EN];
		master = en & st.ctrl[C_MASTER];
		slave  = en & ~st.ctrl[C_MASTER];
		cpha   = st.ctrl[C_CPHA];
		cpol   = st.ctrl[C_CPOL];
		tmde   = st.ctrl[C_TMDE];
		rfl    = st.ctrl[C_RFLUSH];
		tfl    = st.ctrl[C_TFLUSH];
		mode   = st.ctrl[C_MODE +: 2];
		sel    = reg_sel(apb_req.paddr);
		setup  = apb_req.psel & ~apb_req.penable;
		rd     = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
		wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
		edge_ev = 1'b0;
		lead    = 1'b0;
		load    = 1'b0;
		done    = 1'b0;
		start   = 1'b0;
		ev      = 5'h00;
		clr     = 5'h00;
		// read data is captured in setup; only flags seen there are cleared later
		if (setup) begin
			case (1'b1)
				sel[R_STATUS]: next_st.prdata = status_word(st, mode);
				// empty fifo reads zero, so flushed bytes left in storage stay hidden
				sel[R_RX]:     next_st.prdata = {24'h00_0000, (st.rx_cnt != 3'h0) ? st.rxq[0] : 8'h00};
				sel[R_DIV]:    next_st.prdata = {24'h00_0000, st.div};
				sel[R_CTRL]:   next_st.prdata = {16'h0000, st.ctrl};
				default:       next_st.prdata = 32'h0000_0000;
			endcase
		end
		if (rd & sel[R_STATUS]) begin
			clr = {st.prdata[7], st.prdata[6], st.prdata[5], st.prdata[4], st.prdata[0]};
		end
		if (wr & sel[R_CTRL]) begin
			next_st.ctrl = apb_req.pwdata[15:0];
		end
		if (wr & sel[R_DIV]) begin
			next_st.div = apb_req.pwdata[7:0];
		end
		if (rd & sel[R_RX] & (st.rx_cnt != 3'h0)) begin
			next_st.rxq    = {8'h00, st.rxq[3:1]};
			next_st.rx_cnt = st.rx_cnt - 3'h1;
		end
		case (st.fsm)
			P_IDLE: begin
				next_st.sclk = cpol;
				next_st.cs_n = 1'b1;
				// tx mode starts on queued data, rx mode on a read of the rx register
				if (master & (tmde ? (st.tx_cnt != 3'h0) : (rd & sel[R_RX]))) begin
					start = 1'b1;
				end
				if (slave & ~st.cs_s[1]) begin
					start = 1'b1;
				end
				if (start) begin
					next_st.fsm      = P_XFER;
					next_st.first    = cpha;
					next_st.bits     = 4'h0;
					next_st.divcnt   = 8'h00;
					next_st.edge_cnt = 5'h00;
					next_st.cs_n     = ~master;
					load             = 1'b1;
				end
			end
			P_XFER: begin
				if (st.ctrl[C_MASTER]) begin
					if (st.divcnt == st.div) begin
						next_st.divcnt   = 8'h00;
						next_st.sclk     = ~st.sclk;
						edge_ev          = 1'b1;
						lead             = ~st.edge_cnt[0];
						next_st.edge_cnt = st.edge_cnt + 5'h01;
						if (st.edge_cnt == LAST_EDGE) begin
							next_st.fsm      = P_STALL;
							next_st.cs_n     = 1'b1;
							next_st.edge_cnt = 5'h00;
						end
					end else begin
						next_st.divcnt = st.divcnt + 8'h01;
					end
				end else begin
					edge_ev = st.sclk_s[1] ^ st.sclk_prev;
					lead    = st.sclk_s[1] ^ cpol;
					if (st.cs_s[1]) begin
						next_st.fsm = P_IDLE;
					end
				end
				if (~en) begin
					next_st.fsm = P_IDLE;
				end
			end
			P_STALL: begin
				// one idle serial period between master bytes
				if (st.divcnt == st.div) begin
					next_st.divcnt   = 8'h00;
					next_st.edge_cnt = st.edge_cnt + 5'h01;
					if (st.edge_cnt == STALL_HALVES) begin
						next_st.fsm = P_IDLE;
					end
				end else begin
					next_st.divcnt = st.divcnt + 8'h01;
				end
			end
			default: begin
				next_st.fsm = P_IDLE;
			end
		endcase
		// loopback ties the receiver to our own transmit bit
		din     = st.ctrl[C_LOOP] ? st.tx_sh[7] : (st.ctrl[C_MASTER] ? st.miso_s[1] : st.mosi_s[1]);
		smp     = edge_ev & (lead ^ cpha);
		lnch    = edge_ev & ~(lead ^ cpha);
		byte_in = {st.rx_sh[6:0], din};
		if (smp) begin
			next_st.rx_sh = byte_in;
			next_st.bits  = st.bits + 4'h1;
			if (st.bits == LAST_BIT) begin
				done         = 1'b1;
				next_st.bits = 4'h0;
			end
		end
		if (lnch) begin
			if (st.first) begin
				next_st.first = 1'b0;
			end else begin
				next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
			end
		end
		// slave keeps exchanging bytes for as long as it stays selected
		if (done & ~st.ctrl[C_MASTER]) begin
			load          = 1'b1;
			next_st.first = 1'b1;
		end
		if (load) begin
			if (tfl | (st.tx_cnt == 3'h0)) begin
				next_st.tx_sh = 8'h00;
				ev[F_UNF]     = 1'b1;
			end else begin
				next_st.tx_sh  = st.txq[0];
				next_st.txq    = {8'h00, st.txq[3:1]};
				next_st.tx_cnt = st.tx_cnt - 3'h1;
			end
		end
		// a full tx fifo ignores the write and keeps its bytes
		if (wr & sel[R_TX] & ~tfl & (next_st.tx_cnt < FIFO_DEPTH)) begin
			next_st.txq[next_st.tx_cnt[1:0]] = apb_req.pwdata[7:0];
			next_st.tx_cnt                   = next_st.tx_cnt + 3'h1;
		end
		if (tfl) begin
			next_st.tx_cnt = 3'h0;
		end
		if (rfl) begin
			next_st.rx_cnt = 3'h0;
		end
		if (done & ~rfl) begin
			if (next_st.rx_cnt == FIFO_DEPTH) begin
				ev[F_OVF] = 1'b1;
			end else begin
				next_st.rxq[next_st.rx_cnt[1:0]] = byte_in;
				next_st.rx_cnt                   = next_st.rx_cnt + 3'h1;
			end
			ev[F_RXI] = ~tmde & (next_st.rx_cnt > {1'b0, mode});
		end
		if (done & tmde) begin
			if (st.txd_cnt == mode) begin
				ev[F_TXI]       = ~rfl;
				next_st.txd_cnt = 2'h0;
			end else begin
				next_st.txd_cnt = st.txd_cnt + 2'h1;
			end
		end
		ev[F_ANY]   = ev[F_OVF] | ev[F_RXI] | ev[F_TXI] | (ev[F_UNF] & ~tfl);
		next_st.flg = (st.flg & ~clr) | ev;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st        <= '0;
			st.fsm    <= P_IDLE;
			st.ctrl   <= CTRL_RST;
			st.div    <= DIV_RST;
			st.cs_n   <= 1'b1;
			st.cs_s   <= 2'b11;
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp.prdata  = st.prdata;
	assign apb_rsp.pready  = apb_req.psel & apb_req.penable;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & (sel == 5'h00);

	assign pin_out.serial_clock_line_o  = st.sclk;
	assign pin_out.serial_clock_line_oe = master;
	assign pin_out.mosi_o               = st.tx_sh[7];
	assign pin_out.mosi_oe              = master;
	assign pin_out.miso_o               = st.tx_sh[7];
	assign pin_out.miso_oe              = slave & st.ctrl[C_MISO_OE] & (st.fsm == P_XFER);
	assign pin_out.cs_n_o               = st.cs_n;
	assign pin_out.cs_n_oe              = master;

	// helper counters read only by assertions
	logic [8:0] hp_cnt;
	logic [4:0] fe_cnt;
	always_ff @(posedge clk) begin
		if (srst) begin
			hp_cnt <= 9'h000;
			fe_cnt <= 5'h00;
		end else begin
			hp_cnt <= ((st.fsm != P_XFER) || (st.sclk != next_st.sclk)) ? 9'h000 : hp_cnt + 9'h001;
			fe_cnt <= next_st.cs_n ? 5'h00 : fe_cnt + {4'h0, st.sclk != next_st.sclk};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_dir;
		wr && sel[R_CTRL] && apb_req.pwdata[C_EN] && apb_req.pwdata[C_MASTER]
			|=> pin_out.mosi_oe && !pin_out.miso_oe;
	endproperty
	a_dir: assert property (p_dir) else $error("master mode pin directions wrong");
	property p_clk_in;
		wr && sel[R_CTRL] && !apb_req.pwdata[C_MASTER] |=> !pin_out.serial_clock_line_oe;
	endproperty
	a_clk_in: assert property (p_clk_in) else $error("slave drives serial clock");
	property p_half;
		st.fsm == P_XFER && st.ctrl[C_MASTER] && st.sclk != next_st.sclk
			|-> hp_cnt == {1'b0, st.div};
	endproperty
	a_half: assert property (p_half) else $error("serial half period wrong");
	property p_frame;
		!st.cs_n && next_st.cs_n && st.ctrl[C_MASTER]
			|-> fe_cnt == LAST_EDGE && st.sclk != next_st.sclk;
	endproperty
	a_frame: assert property (p_frame) else $error("frame not sixteen edges");
	property p_cs_low;
		st.fsm == P_IDLE && start && master |=> !pin_out.cs_n_o ##1 !pin_out.cs_n_o;
	endproperty
	a_cs_low: assert property (p_cs_low) else $error("chip select not asserted");
	property p_msb;
		st.fsm == P_IDLE && start && master && !tfl && st.tx_cnt != 3'h0
			|=> pin_out.mosi_o == $past(st.txq[0][7]);
	endproperty
	a_msb: assert property (p_msb) else $error("first bit not msb");
	property p_slave_end;
		st.fsm == P_XFER && !st.ctrl[C_MASTER] && st.cs_s[1] |=> st.fsm == P_IDLE;
	endproperty
	a_slave_end: assert property (p_slave_end) else $error("slave frame not ended");
	property p_set_wins;
		ev[F_OVF] && clr[F_OVF] |=> st.flg[F_OVF] && st.flg[F_ANY];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to read clear");
	property p_ovf;
		ev[F_OVF] |=> st.rx_cnt == FIFO_DEPTH && $stable(st.rxq);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow corrupted rx fifo");
	property p_full;
		wr && sel[R_TX] && st.tx_cnt == FIFO_DEPTH && !load && !tfl
			|=> st.tx_cnt == FIFO_DEPTH && $stable(st.txq);
	endproperty
	a_full: assert property (p_full) else $error("full tx fifo changed");
	property p_rx_lvl;
		setup && sel[R_STATUS] |=> apb_rsp.prdata[10:8] == $past(st.rx_cnt);
	endproperty
	a_rx_lvl: assert property (p_rx_lvl) else $error("rx level field wrong");
	property p_tx_lvl;
		setup && sel[R_STATUS] |=> apb_rsp.prdata[3:1] == $past(st.tx_cnt);
	endproperty
	a_tx_lvl: assert property (p_tx_lvl) else $error("tx level field wrong");
	// a full rx fifo exceeds every threshold but the four-byte one
	property p_rex_hi;
		setup && sel[R_STATUS] && st.rx_cnt == FIFO_DEPTH && mode != 2'h3
			|=> apb_rsp.prdata[11];
	endproperty
	a_rex_hi: assert property (p_rex_hi) else $error("rx excess not shown");
	property p_rex_lo;
		setup && sel[R_STATUS] && st.rx_cnt == 3'h0 |=> !apb_rsp.prdata[11];
	endproperty
	a_rex_lo: assert property (p_rex_lo) else $error("rx excess shown when empty");
	property p_rxi;
		done && !tmde && !rfl && st.rx_cnt == 3'h0 && mode == 2'h0
			|=> st.flg[F_RXI] && st.flg[F_ANY];
	endproperty
	a_rxi: assert property (p_rxi) else $error("rx interrupt missing");
	property p_txi;
		done && tmde && !rfl && mode == 2'h0 |=> st.flg[F_TXI] && st.flg[F_ANY];
	endproperty
	a_txi: assert property (p_txi) else $error("tx interrupt missing");
	property p_unf;
		load && st.tx_cnt == 3'h0 |=> st.flg[F_UNF];
	endproperty
	a_unf: assert property (p_unf) else $error("tx underflow missing");
	property p_any;
		$rose(st.flg[F_OVF]) || $rose(st.flg[F_RXI]) || $rose(st.flg[F_TXI])
			|-> st.flg[F_ANY];
	endproperty
	a_any: assert property (p_any) else $error("summary flag missing");
	property p_clr;
		rd && sel[R_STATUS] && st.prdata[0] && ev == 5'h00 |=> !st.flg[F_ANY];
	endproperty
	a_clr: assert property (p_clr) else $error("summary flag not cleared");
	// flush keeps the rx fifo empty for as long as it is set
	property p_rx_flush;
		rfl |=> st.rx_cnt == 3'h0;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("rx flush kept bytes");
	property p_flush_quiet;
		rfl |-> !ev[F_RXI] && !ev[F_OVF] && !ev[F_TXI];
	endproperty
	a_flush_quiet: assert property (p_flush_quiet) else $error("irq during rx flush");
	property p_slave_pins;
		slave |-> !pin_out.cs_n_oe && !pin_out.serial_clock_line_oe && !pin_out.mosi_oe;
	endproperty
	a_slave_pins: assert property (p_slave_pins) else $error("slave drives an input");
	property p_idle_clk;
		st.fsm == P_IDLE && master |=> pin_out.serial_clock_line_o == $past(st.ctrl[C_CPOL]);
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("serial clock idle level");
	property p_depth;
		st.rx_cnt <= FIFO_DEPTH && st.tx_cnt <= FIFO_DEPTH;
	endproperty
	a_depth: assert property (p_depth) else $error("fifo level beyond depth");
endmodule: spi_port_with_status

// ==== bench/spi_far_device.sv ====
// behavioural spi slave on the far side of the port in master mode
module spi_far_device (
	// serial pins as seen by the far device
	input  wire logic sclk,
	input  wire logic mosi,
	input  wire logic cs_n,
	output logic      miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] out_sh;
	logic [7:0] in_sh;
	logic [7:0] seen [0:7];
	int         bits;
	int         frames;
	initial begin
		miso = 1'b0;
		bits = 0;
		frames = 0;
	end
	// bit 7 must stand before the first sampling edge
	always @(negedge cs_n) begin
		out_sh = 8'hc3 ^ 8'(frames);
		miso = out_sh[7];
		bits = 0;
	end
	always @(posedge sclk) if (!cs_n) begin
		in_sh = {in_sh[6:0], mosi};
		bits++;
		if (bits == 8) begin
			seen[frames[2:0]] = in_sh;
			frames++;
		end
	end
	always @(negedge sclk) if (!cs_n && bits < 8) begin
		out_sh = out_sh << 1;
		miso = out_sh[7];
	end
	// released line shows the inverse, never a stale bit
	always @(posedge cs_n) miso = ~miso;
endmodule: spi_far_device

// ==== bench/tb_top.sv ====
// self-checking bench for the spi port with status
module tb_top import spi_port_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 2;
	localparam int PERIOD = 2 * (DIV + 1);
	localparam logic [7:0] SLAVE_BYTE = 8'ha5;
	logic        clk;
	logic        srst;
	apb_req_s    apb_req;
	apb_rsp_s    apb_rsp;
	pin_in_s     pin_in;
	pin_out_s    pin_out;
	logic        tb_sclk;
	logic        tb_mosi;
	logic        tb_cs_n;
	logic        far_miso;
	logic [31:0] rd;
	logic        err;
	logic        sclk_q;
	logic        cs_q;
	int          edges = 0;
	int          gap = 0;
	int          fails = 0;
	int          compares = 0;

	// each line resolved from whoever enables it
	assign pin_in.serial_clock_line = pin_out.serial_clock_line_oe ?
		pin_out.serial_clock_line_o : tb_sclk;
	assign pin_in.mosi = pin_out.mosi_oe ? pin_out.mosi_o : tb_mosi;
	assign pin_in.miso = pin_out.miso_oe ? pin_out.miso_o : far_miso;
	assign pin_in.cs_n = pin_out.cs_n_oe ? pin_out.cs_n_o : tb_cs_n;

	spi_port_with_status i_dut (
		.clk     (clk),
		.srst    (srst),
		.apb_req (apb_req),
		.apb_rsp (apb_rsp),
		.pin_in  (pin_in),
		.pin_out (pin_out)
	);

	spi_far_device i_far (
		.sclk (pin_in.serial_clock_line),
		.mosi (pin_in.mosi),
		.cs_n (pin_in.cs_n),
		.miso (far_miso)
	);

	initial clk = 1'b0;
	always #10 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask: chk

	// serial clock rate and edge count per frame, master mode only
	always @(posedge clk) begin
		if (pin_out.cs_n_oe === 1'b1) begin
			gap++;
			if (!pin_out.cs_n_o && pin_out.serial_clock_line_o && !sclk_q) begin
				if (edges > 0) chk(32'(gap), 32'(PERIOD));
				gap = 0;
				edges++;
			end
			if (pin_out.cs_n_o && !cs_q) begin
				chk(32'(edges), 32'd8);
				edges = 0;
			end
		end
		sclk_q = pin_out.serial_clock_line_o;
		cs_q = pin_out.cs_n_o;
	end

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask: apb

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask: rd_chk

	task automatic wait_frames(input int k);
		int n;
		n = 0;
		while ((i_far.frames < k || pin_out.cs_n_o !== 1'b1) && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) fails++;
		repeat (PERIOD) @(posedge clk);
	endtask: wait_frames

	task automatic t_regs;
		rd_chk(ADDR_STATUS, 32'h0000_0000);
		rd_chk(ADDR_CTRL, 32'h0000_0000);
		apb(1'b1, ADDR_DIV, 32'h0000_00a5);
		rd_chk(ADDR_DIV, 32'h0000_00a5);
		rd_chk(32'hffff_0a14, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
	endtask: t_regs

	task automatic t_master;
		for (int i = 1; i <= 5; i++) apb(1'b1, ADDR_TX, 32'(8'h11 * i));
		rd_chk(ADDR_STATUS, 32'h0000_0008);
		apb(1'b1, ADDR_DIV, 32'(DIV));
		apb(1'b1, ADDR_CTRL, 32'h0000_0043);
		wait_frames(4);
		for (int i = 0; i < 4; i++) chk(32'(i_far.seen[i]), 32'(8'h11 * (i + 1)));
		rd_chk(ADDR_STATUS, 32'h0000_0c21);
		rd_chk(ADDR_STATUS, 32'h0000_0c00);
		apb(1'b1, ADDR_TX, 32'h0000_0066);
		wait_frames(5);
		chk(32'(i_far.seen[4]), 32'h0000_0066);
		rd_chk(ADDR_STATUS, 32'h0000_0ca1);
		rd_chk(ADDR_RX, 32'h0000_00c3);
		rd_chk(ADDR_STATUS, 32'h0000_0b00);
	endtask: t_master

	task automatic t_rx_mode;
		apb(1'b1, ADDR_CTRL, 32'h0000_1003);
		rd_chk(ADDR_STATUS, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		rd_chk(ADDR_RX, 32'h0000_0000);
		wait_frames(6);
		chk(32'(i_far.seen[5]), 32'h0000_0000);
		rd_chk(ADDR_STATUS, 32'h0000_0151);
	endtask: t_rx_mode

	task automatic t_slave;
		apb(1'b1, ADDR_CTRL, 32'h0000_0201);
		repeat (4) @(posedge clk);
		chk(32'({pin_out.serial_clock_line_oe, pin_out.mosi_oe, pin_out.cs_n_oe}), 0);
		tb_cs_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk(32'(pin_out.miso_oe), 32'h0000_0001);
		// one byte from an external master, rising edge samples
		for (int i = 7; i >= 0; i--) begin
			tb_mosi <= SLAVE_BYTE[i];
			repeat (4) @(posedge clk);
			tb_sclk <= 1'b1;
			repeat (4) @(posedge clk);
			tb_sclk <= 1'b0;
		end
		repeat (6) @(posedge clk);
		tb_cs_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk(32'(pin_out.miso_oe), 32'h0000_0000);
		rd_chk(ADDR_STATUS, 32'h0000_0a51);
		rd_chk(ADDR_RX, 32'h0000_00c6);
		rd_chk(ADDR_RX, 32'(SLAVE_BYTE));
	endtask: t_slave

	task automatic end_of_test;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask: end_of_test

	initial begin
		srst = 1'b1;
		apb_req = '0;
		tb_sclk = 1'b0;
		tb_mosi = 1'b0;
		tb_cs_n = 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_master();
		t_rx_mode();
		t_slave();
		end_of_test();
	end

	// cut a hang short well past the expected run time
	initial begin
		#400_000;
		fails++;
		end_of_test();
	end
endmodule: tb_top
